// File: hdl/nvm_cmd_pkg.sv
// constants for the serial eeprom command block: register map, fields,
// reset values and timing counts; used by the top and the op engine
package nvm_cmd_pkg;
	// register byte offsets
	localparam logic [11:0] EEPROM_COMMAND_OFS = 12'h0B0;
	localparam logic [11:0] EEPROM_DATA_OFS = 12'h0B4;
	localparam logic [11:0] STATION_LO_OFS = 12'h0B8;
	localparam logic [11:0] STATION_HI_OFS = 12'h0BC;
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h0C0;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h0C4;
	// command register fields
	localparam int BUSY_BIT = 31;
	localparam int OP_CODE_LSB = 28;
	localparam int OP_CODE_W = 3;
	localparam int TIMEOUT_BIT = 9;
	localparam int LOADED_BIT = 8;
	localparam int ADDR_W = 8;
	// op codes
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	// interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_TIMEOUT_BIT = 1;
	localparam int IRQ_W = 2;
	// reset values
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// station address bytes fetched after reset, from eeprom address 0
	localparam logic [2:0] STATION_BYTES = 3'h6;
	localparam logic [2:0] STATION_LAST = 3'h5;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int OP_TIMEOUT_US = 10;
	localparam int OP_TIMEOUT_CYC = OP_TIMEOUT_US * CLK_MHZ;
	localparam int TMR_W = 12;
endpackage

// File: hdl/nvm_op_engine.sv
// one eeprom byte operation: four-phase request/acknowledge towards the
// serial wire engine, with timeout; ack arrives from another domain
`timescale 1ns/100ps
module nvm_op_engine (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// from the command logic
	input wire logic start,
	input wire logic isWrite,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic done,
	output logic timedOut,
	output logic [7:0] rdata,
	// towards the serial wire engine
	output logic nvmReq,
	output logic nvmWrite,
	output logic [7:0] nvmAddr,
	output logic [7:0] nvmWdata,
	input wire logic nvmAck,
	input wire logic [7:0] nvmRdata
);
	typedef enum logic [1:0] {IDLE, REQUEST, RELEASE} eng_e;
	eng_e state;
	logic ackS1, ackS2, ackS3;
	logic ackHigh, ackLow;
	logic [nvm_cmd_pkg::TMR_W-1:0] timer;
	logic expired;

	// three stages; only the last two are compared
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ackS1 <= 1'b0;
			ackS2 <= 1'b0;
			ackS3 <= 1'b0;
		end else begin
			ackS1 <= nvmAck;
			ackS2 <= ackS1;
			ackS3 <= ackS2;
		end
	end
	assign ackHigh = ackS2 & ackS3;
	assign ackLow = !ackS2 & !ackS3;
	assign expired =
		(timer == nvm_cmd_pkg::TMR_W'(nvm_cmd_pkg::OP_TIMEOUT_CYC - 1));

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			timer <= '0;
		end else if (state == REQUEST && !ackHigh) begin
			timer <= timer + 1'b1;
		end else begin
			timer <= '0;
		end
	end

	// [RULE_05] timeout ends op
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= IDLE;
			done <= 1'b0;
			timedOut <= 1'b0;
			nvmReq <= 1'b0;
		end else begin
			done <= 1'b0;
			timedOut <= 1'b0;
			case (state)
				IDLE: begin
					if (start) begin
						nvmReq <= 1'b1;
						state <= REQUEST;
					end
				end
				REQUEST: begin
					if (ackHigh) begin
						nvmReq <= 1'b0;
						state <= RELEASE;
					end else if (expired) begin
						// no part fitted: give up this op and return to IDLE without waiting on ack
						nvmReq <= 1'b0;
						timedOut <= 1'b1;
						state <= IDLE;
					end
				end
				RELEASE: begin
					if (ackLow) begin
						done <= 1'b1;
						state <= IDLE;
					end
				end
				default: begin
					state <= IDLE;
				end
			endcase
		end
	end

	// request fields held steady across the handshake
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			nvmWrite <= 1'b0;
			nvmAddr <= nvm_cmd_pkg::BYTE_RESET;
			nvmWdata <= nvm_cmd_pkg::BYTE_RESET;
		end else if (state == IDLE && start) begin
			nvmWrite <= isWrite;
			nvmAddr <= addr;
			nvmWdata <= wdata;
		end
	end

	// read data is stable while ack is high on the far side
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rdata <= nvm_cmd_pkg::BYTE_RESET;
		end else if (state == REQUEST && ackHigh) begin
			rdata <= nvmRdata;
		end
	end
endmodule

// File: hdl/serial_eeprom_command_control.sv
// eeprom command and busy handshake with apb register access, station
// address load after reset and a level interrupt
// assumes an apb master on mclk and a serial engine answering req/ack
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
// Overview of operation
// [RULE_01] writing busy bit 31 as one starts the selected op
// [RULE_02] busy stays one during the op and clears itself at the end
// [RULE_03] read data sits in the data register before busy clears
// [RULE_04] software leaves command and data registers alone while busy
// [RULE_05] write with no eeprom keeps busy until timeout, then clears
// [RULE_06] busy reads one straight after reset
// [RULE_07] after reset station address is loaded, busy clears when done
// [RULE_08] op code and address captured at start, used throughout
module serial_eeprom_command_control (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// station address as loaded
	output logic [47:0] stationAddr,
	// serial wire engine
	output logic nvmReq,
	output logic nvmWrite,
	output logic [7:0] nvmAddr,
	output logic [7:0] nvmWdata,
	input wire logic nvmAck,
	input wire logic [7:0] nvmRdata
);
	typedef enum logic [1:0] {BOOT, BOOT_WAIT, READY, RUN} ctl_e;
	ctl_e state;
	logic nvmOpBusy;
	logic [2:0] nvmOpCode;
	logic [7:0] opAddr;
	logic nvmOpTimeout;
	logic loaded;
	logic [7:0] eepromDataReg;
	logic [2:0] loadIdx;
	localparam int IRQ_W_T = nvm_cmd_pkg::IRQ_W;
	logic [IRQ_W_T-1:0] irqStatus;
	logic [IRQ_W_T-1:0] irqMask;
	logic start, startWrite;
	logic [7:0] startAddr;
	logic opDone, opTimedOut;
	logic [7:0] opRdata;
	logic wrAcc, rdAcc, setup, mapped;
	logic [31:0] eepromCommandReg;
	logic [31:0] next_prdata;

	assign setup = psel & !penable;
	assign pready = psel & penable;
	assign wrAcc = pready & pwrite & !pslverr;
	assign rdAcc = pready & !pwrite & !pslverr;
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			nvm_cmd_pkg::EEPROM_COMMAND_OFS,
			nvm_cmd_pkg::EEPROM_DATA_OFS,
			nvm_cmd_pkg::STATION_LO_OFS,
			nvm_cmd_pkg::STATION_HI_OFS,
			nvm_cmd_pkg::IRQ_STATUS_OFS,
			nvm_cmd_pkg::IRQ_MASK_OFS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = pready & !mapped;

	always_comb begin
		eepromCommandReg = '0;
		eepromCommandReg[nvm_cmd_pkg::BUSY_BIT] = nvmOpBusy;
		eepromCommandReg[nvm_cmd_pkg::OP_CODE_LSB +: nvm_cmd_pkg::OP_CODE_W] =
			nvmOpCode;
		eepromCommandReg[nvm_cmd_pkg::TIMEOUT_BIT] = nvmOpTimeout;
		eepromCommandReg[nvm_cmd_pkg::LOADED_BIT] = loaded;
		eepromCommandReg[nvm_cmd_pkg::ADDR_W-1:0] = opAddr;
	end

	always_comb begin
		case (paddr)
			nvm_cmd_pkg::EEPROM_COMMAND_OFS: next_prdata = eepromCommandReg;
			nvm_cmd_pkg::EEPROM_DATA_OFS: next_prdata = {24'h000000, eepromDataReg};
			nvm_cmd_pkg::STATION_LO_OFS: next_prdata = stationAddr[31:0];
			nvm_cmd_pkg::STATION_HI_OFS: next_prdata = {16'h0000, stationAddr[47:32]};
			nvm_cmd_pkg::IRQ_STATUS_OFS: next_prdata = {30'h00000000, irqStatus};
			nvm_cmd_pkg::IRQ_MASK_OFS: next_prdata = {30'h00000000, irqMask};
			default: next_prdata = '0;
		endcase
	end

	// read data latched in setup, stable through the access phase
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			prdata <= '0;
		end else if (setup) begin
			prdata <= next_prdata;
		end
	end

	// [RULE_06] busy set out of reset
	// [RULE_07] station load then clear
	// [RULE_02] self clearing busy
	// [RULE_05] timeout clears busy
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= BOOT;
			nvmOpBusy <= 1'b1;
			loadIdx <= 3'h0;
			loaded <= 1'b0;
			nvmOpTimeout <= 1'b0;
		end else begin
			case (state)
				BOOT: begin
					state <= BOOT_WAIT;
				end
				BOOT_WAIT: begin
					if (opTimedOut) begin
						nvmOpBusy <= 1'b0;
						nvmOpTimeout <= 1'b1;
						state <= READY;
					end else if (opDone && loadIdx == nvm_cmd_pkg::STATION_LAST) begin
						nvmOpBusy <= 1'b0;
						loaded <= 1'b1;
						state <= READY;
					end else if (opDone) begin
						loadIdx <= loadIdx + 3'h1;
						state <= BOOT;
					end
				end
				READY: begin
					// [RULE_01] busy write starts
					if (wrAcc && paddr == nvm_cmd_pkg::EEPROM_COMMAND_OFS &&
						pwdata[nvm_cmd_pkg::BUSY_BIT]) begin
						nvmOpBusy <= 1'b1;
						nvmOpTimeout <= 1'b0;
						state <= RUN;
					end
				end
				RUN: begin
					if (opDone || opTimedOut) begin
						nvmOpBusy <= 1'b0;
						nvmOpTimeout <= opTimedOut;
						state <= READY;
					end
				end
				default: begin
					state <= READY;
				end
			endcase
		end
	end

	// [RULE_08] fields captured at start
	// [RULE_04] writes while busy dropped
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			nvmOpCode <= nvm_cmd_pkg::OP_READ;
			opAddr <= nvm_cmd_pkg::BYTE_RESET;
		end else if (state == READY && wrAcc &&
			paddr == nvm_cmd_pkg::EEPROM_COMMAND_OFS) begin
			nvmOpCode <= pwdata[nvm_cmd_pkg::OP_CODE_LSB +: nvm_cmd_pkg::OP_CODE_W];
			opAddr <= pwdata[nvm_cmd_pkg::ADDR_W-1:0];
		end
	end

	assign start = (state == BOOT) || (state == READY && wrAcc &&
		paddr == nvm_cmd_pkg::EEPROM_COMMAND_OFS &&
		pwdata[nvm_cmd_pkg::BUSY_BIT]);
	assign startWrite = (state == READY) &&
		(pwdata[nvm_cmd_pkg::OP_CODE_LSB +: nvm_cmd_pkg::OP_CODE_W] ==
		nvm_cmd_pkg::OP_WRITE);
	assign startAddr = (state == BOOT) ? {5'h00, loadIdx} :
		pwdata[nvm_cmd_pkg::ADDR_W-1:0];

	// [RULE_03] data ready with busy clear
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			eepromDataReg <= nvm_cmd_pkg::BYTE_RESET;
		end else if (state == RUN && opDone &&
			nvmOpCode == nvm_cmd_pkg::OP_READ) begin
			eepromDataReg <= opRdata;
		end else if (state == READY && wrAcc &&
			paddr == nvm_cmd_pkg::EEPROM_DATA_OFS) begin
			eepromDataReg <= pwdata[7:0];
		end
	end

	// [RULE_07] station bytes stored
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			stationAddr <= '0;
		end else if (state == BOOT_WAIT && opDone) begin
			stationAddr[8*loadIdx +: 8] <= opRdata;
		end
	end

	// set wins over the read clear; only bits latched into prdata at setup
	// are cleared, so an event landing on the setup edge is not lost
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irqStatus <= nvm_cmd_pkg::IRQ_RESET;
			irqMask <= nvm_cmd_pkg::IRQ_RESET;
		end else begin
			irqStatus <= (rdAcc && paddr == nvm_cmd_pkg::IRQ_STATUS_OFS) ?
				((irqStatus & ~prdata[IRQ_W_T-1:0]) | {opTimedOut, opDone}) :
				(irqStatus | {opTimedOut, opDone});
			if (wrAcc && paddr == nvm_cmd_pkg::IRQ_MASK_OFS) begin
				irqMask <= pwdata[IRQ_W_T-1:0];
			end
		end
	end
	assign irq = |(irqStatus & irqMask);

	nvm_op_engine nvm_op_engine_i (
		.mclk(mclk),
		.rstn(rstn),
		.start(start),
		.isWrite(startWrite),
		.addr(startAddr),
		.wdata(eepromDataReg),
		.done(opDone),
		.timedOut(opTimedOut),
		.rdata(opRdata),
		.nvmReq(nvmReq),
		.nvmWrite(nvmWrite),
		.nvmAddr(nvmAddr),
		.nvmWdata(nvmWdata),
		.nvmAck(nvmAck),
		.nvmRdata(nvmRdata)
	);
endmodule

// File: verif/serial_eeprom_command_control_properties.sv
// assertion checker for the eeprom command block, bound to its top
// assumes a protocol-clean apb master and req/ack partner
`timescale 1ns/100ps
module nvm_cmd_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// serial engine link
	input wire logic nvmReq,
	input wire logic nvmWrite,
	input wire logic [7:0] nvmAddr,
	input wire logic [7:0] nvmWdata,
	input wire logic nvmAck
);
	logic [11:0] reqCnt;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// open request age, bounds the timeout
	always_ff @(posedge mclk) begin
		if (!rstn || !nvmReq)
			reqCnt <= 12'h000;
		else
			reqCnt <= reqCnt + 12'h001;
	end
	boot_req_a: assert property ($rose(rstn)
		|-> ##[1:3] nvmReq && !nvmWrite && nvmAddr == 8'h00)
		else $error("boot load request missing");
	field_hold_a: assert property (nvmReq && $past(nvmReq)
		|-> $stable(nvmAddr) && $stable(nvmWrite) && $stable(nvmWdata))
		else $error("request fields moved");
	ack_drop_a: assert property (nvmReq && nvmAck
		|-> ##[1:6] !nvmReq)
		else $error("request held after ack");
	req_bound_a: assert property (reqCnt <= 12'h7D3)
		else $error("request outlived timeout");
	drop_cause_a: assert property ($fell(nvmReq)
		|-> $past(nvmAck) || $past(reqCnt) > 12'h7C6)
		else $error("request dropped without cause");
	busy_read_a: assert property (psel && penable && !pwrite
		&& paddr == 12'h0B0 && nvmReq && $past(nvmReq) |-> prdata[31])
		else $error("busy low during operation");
	bad_addr_a: assert property (psel && penable
		&& paddr > 12'h0C4 |-> pslverr)
		else $error("unmapped access not flagged");
endmodule
bind serial_eeprom_command_control nvm_cmd_checker nvm_cmd_checker_i (
	.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.nvmReq(nvmReq), .nvmWrite(nvmWrite), .nvmAddr(nvmAddr),
	.nvmWdata(nvmWdata), .nvmAck(nvmAck));

// File: verif/nvm_partner.sv
// behavioural serial eeprom engine on the req/ack link
// assumes request fields hold until ack is seen
`timescale 1ns/100ps
module nvm_partner (
	// clock and bench controls
	input wire logic mclk,
	input wire logic absent,
	input wire logic [3:0] lag,
	// link
	input wire logic nvmReq,
	input wire logic nvmWrite,
	input wire logic [7:0] nvmAddr,
	input wire logic [7:0] nvmWdata,
	output logic nvmAck,
	output logic [7:0] nvmRdata
);
	logic [7:0] mem [256];
	logic [3:0] cnt;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
	end
	// a missing part never answers
	always @(posedge mclk) begin
		if (!nvmReq) begin
			nvmAck <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt < lag)
			cnt <= cnt + 4'h1;
		else if (!absent && !nvmAck) begin
			nvmAck <= 1'b1;
			if (nvmWrite)
				mem[nvmAddr] <= nvmWdata;
		end
	end
	// junk outside the ack window
	assign nvmRdata = nvmAck ? mem[nvmAddr] : ~mem[nvmAddr];
endmodule

// File: verif/test_serial_eeprom_command_control.sv
// self-checking bench for the eeprom command block
// assumes the checker binds itself from its own file
`timescale 1ns/100ps
module test_serial_eeprom_command_control;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, irq, nvmReq, nvmWrite, nvmAck, err;
	logic [47:0] stationAddr;
	logic [7:0] nvmAddr, nvmWdata, nvmRdata;
	logic absent = 1'b0;
	logic [3:0] lag = 4'h0;
	int error_cnt = 0;
	int compares = 0;
	always #2.5 mclk = ~mclk;
	serial_eeprom_command_control serial_eeprom_command_control_i (
		.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.stationAddr(stationAddr), .nvmReq(nvmReq), .nvmWrite(nvmWrite),
		.nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmAck(nvmAck),
		.nvmRdata(nvmRdata));
	nvm_partner nvm_partner_i (.mclk(mclk), .absent(absent), .lag(lag),
		.nvmReq(nvmReq), .nvmWrite(nvmWrite), .nvmAddr(nvmAddr),
		.nvmWdata(nvmWdata), .nvmAck(nvmAck), .nvmRdata(nvmRdata));
	task automatic finish_test();
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang();
		error_cnt++;
		finish_test();
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
		if (n >= 40)
			hang();
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic wait_idle();
		int n;
		q = 32'h8000_0000;
		for (n = 0; n < 1000 && q[31] !== 1'b0; n++)
			rd(12'h0B0);
		if (n >= 1000)
			hang();
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
	endtask
	task automatic t_boot();
		rd(12'h0B0);
		check(q & 32'h8000_0000, 32'h8000_0000);
		wait_idle();
		check(q & 32'h8000_0300, 32'h0000_0100);
		rd(12'h0B8);
		check(q, 32'h5958_5B5A);
		rd(12'h0BC);
		check(q, 32'h0000_5F5E);
		check(stationAddr[47:16], 32'h5F5E_5958);
	endtask
	task automatic t_irq();
		wr(12'h0C4, 32'h0);
		check({31'h0, irq}, 32'h0);
		wr(12'h0C4, 32'h3);
		check({31'h0, irq}, 32'h1);
		rd(12'h0C0);
		check(q & 32'h1, 32'h1);
		check({31'h0, irq}, 32'h0);
		rd(12'h0F0);
		check({31'h0, err}, 32'h1);
	endtask
	task automatic t_read();
		lag <= 4'h6;
		wr(12'h0B0, 32'h8000_0037);
		wr(12'h0B0, 32'h8000_0044);
		rd(12'h0B0);
		check(q & 32'h8000_00FF, 32'h8000_0037);
		wait_idle();
		check({31'h0, irq}, 32'h1);
		rd(12'h0B4);
		check(q & 32'hFF, 32'h6D);
	endtask
	task automatic t_write();
		lag <= 4'h0;
		wr(12'h0B4, 32'h0000_00C3);
		wr(12'h0B0, 32'h9000_0010);
		wait_idle();
		wr(12'h0B4, 32'h0);
		wr(12'h0B0, 32'h8000_0010);
		wait_idle();
		rd(12'h0B4);
		check(q & 32'hFF, 32'hC3);
		rd(12'h0C0);
	endtask
	task automatic t_timeout();
		absent <= 1'b1;
		wr(12'h0B0, 32'h9000_0021);
		repeat (1800) @(posedge mclk);
		rd(12'h0B0);
		check(q & 32'h8000_0000, 32'h8000_0000);
		wait_idle();
		check(q & 32'h8000_0200, 32'h0000_0200);
		check({31'h0, irq}, 32'h1);
		rd(12'h0C0);
		check(q & 32'h2, 32'h2);
		absent <= 1'b0;
	endtask
	task automatic t_boot_fail();
		absent <= 1'b1;
		do_reset();
		wait_idle();
		check(q & 32'h8000_0300, 32'h0000_0200);
		absent <= 1'b0;
	endtask
	task automatic t_rerun();
		lag <= 4'h9;
		wr(12'h0B0, 32'h8000_0001);
		do_reset();
		t_boot();
	endtask
	initial begin
		do_reset();
		t_boot();
		t_irq();
		t_read();
		t_write();
		t_timeout();
		t_boot_fail();
		t_rerun();
		finish_test();
	end
endmodule
